// file: bench/smm_chipset_model.sv
// chipset-side model: raises the management request on command
// assumes: req is a one-cycle pulse, width (>=1) is the low time in cycles
`timescale 1ns/100ps
module smm_chipset_model (
  input  wire logic       sys_clk,
  input  wire logic       req,
  input  wire logic [3:0] width,
  output logic            sys_mgmt_irq_n
);
  logic [3:0] cnt_q = 4'h0; // low cycles still to go

  // request line idles high, so each command is a clean falling edge
  assign sys_mgmt_irq_n = (cnt_q == 4'h0);

  // a long width models a slow chipset, a short one a prompt one
  always @(posedge sys_clk)
  begin
    if (req)
      cnt_q <= width;
    else if (cnt_q != 4'h0)
      cnt_q <= cnt_q - 4'h1;
  end
endmodule

// file: bench/tb_sys_mgmt_mode_entry_exit.sv
// self-checking bench of the management-mode entry/exit sequencer
// assumes: smm_pkg compiled first, chipset model beside it
`timescale 1ns/100ps
module tb_sys_mgmt_mode_entry_exit;
  logic                sys_clk = 1'b0;
  logic                rst_n = 1'b0;
  logic                irq_n, req = 1'b0, a20_n = 1'b0, boundary = 1'b1;
  logic                halted = 1'b0, iov = 1'b0, resume = 1'b0;
  logic                xv = 1'b0, op32 = 1'b0, bus_wr = 1'b0, bus_rd = 1'b0;
  logic [3:0]          req_width = 4'h1;
  logic [31:0]         trap_dw = 32'h0, trap_eip = 32'h0, xeip = 32'h0;
  logic [15:0]         sel = 16'h0;
  logic [8:0]          bus_addr = 9'h0;
  logic [31:0]         bus_wdata = 32'h0, bus_rdata, xeip_q, fbase_q;
  logic                active_n, in_mode, entry_load, restore_load, to_halt, shutdown;
  logic                a20_eff;
  smm_pkg::smm_core_s  cs = '0;
  smm_pkg::smm_entry_s ev;
  smm_pkg::smm_core_s  rv;
  smm_pkg::smm_mode_s  mode_ctl;
  int                  error_cnt = 0, compares = 0;
  logic [31:0]         d, ne, base = 32'h0003_0000; // management base in force
  logic                nh;

  // 100 ns bus clock
  always #50 sys_clk = ~sys_clk;

  smm_chipset_model u_chipset (.sys_clk(sys_clk), .req(req), .width(req_width),
    .sys_mgmt_irq_n(irq_n));

  smm_entry_exit u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .sys_mgmt_irq_n(irq_n),
    .addr_bit20_mask_n(a20_n), .instr_boundary(boundary), .core_halted(halted),
    .core_state(cs), .io_cycle_valid(iov), .io_trap_dword(trap_dw),
    .io_trap_eip(trap_eip), .resume_from_mgmt_instr(resume), .xfer_valid(xv),
    .xfer_op32(op32), .xfer_eip(xeip), .far_selector(sel), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .sys_mgmt_active_n(active_n), .sys_mgmt_mode(in_mode), .entry_load(entry_load),
    .entry_vals(ev), .restore_load(restore_load), .restore_vals(rv),
    .return_to_halt(to_halt), .shutdown(shutdown), .mode_ctl(mode_ctl),
    .a20_mask_eff(a20_eff), .xfer_eip_q(xeip_q), .far_base_q(fbase_q));

  ////////////////////////////////////////////////////////////////////////////
  // verdict, the only exit of the run
  task complete_run;
    if (error_cnt == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // four-state compare, so an unknown never matches
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    compares++;
    if (got !== exp)
    begin
      $display("unexpected %0t %s", $time, m);
      error_cnt++;
    end
  endtask

  // bounded wait on a design output, sampled 1 ns after each edge
  task automatic wait_for(ref logic s, input logic v);
    int n;
    n = 0;
    while (s !== v)
    begin
      @(posedge sys_clk);
      #1;
      n++;
      if (n > 200)
      begin
        $display("unexpected %0t timeout", $time);
        error_cnt++;
        complete_run();
      end
    end
  endtask

  // one-cycle write strobe
  task bwr(input logic [8:0] a, input logic [31:0] w);
    @(posedge sys_clk);
    bus_addr  <= a;
    bus_wdata <= w;
    bus_wr    <= 1'b1;
    @(posedge sys_clk);
    bus_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task brd(input logic [8:0] a);
    @(posedge sys_clk);
    bus_addr <= a;
    bus_rd   <= 1'b1;
    @(posedge sys_clk);
    bus_rd <= 1'b0;
    #1 d = bus_rdata;
  endtask

  // one-cycle resume pulse; the caller waits for the restore
  task do_resume;
    @(posedge sys_clk);
    resume <= 1'b1;
    @(posedge sys_clk);
    resume <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence: two random entries, a pending request, a bad base
  initial
  begin
    void'($urandom(32'h085F0867));
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    #1 chk(active_n, 1'b1, "active after reset");
    chk(in_mode, 1'b0, "mode after reset");
    chk(a20_eff, 1'b1, "a20 mask outside mode");
    // the save area answers zero while the core is not in management mode
    brd(9'h1FC);
    chk(d, 32'h0, "read outside mode");
    for (int r = 0; r < 2; r++)
    begin
      @(posedge sys_clk);
      cs.cr0    <= $urandom;
      cs.cr3    <= $urandom;
      cs.instr_pointer    <= $urandom;
      halted    <= 1'($urandom);
      iov       <= 1'($urandom);
      trap_dw   <= $urandom;
      trap_eip  <= $urandom;
      req_width <= 4'h1 + 4'(r * 6); // prompt, then slow chipset
      req       <= 1'b1;
      @(posedge sys_clk);
      req <= 1'b0;
      wait_for(active_n, 1'b0);
      wait_for(entry_load, 1'b1);
      chk(active_n, 1'b0, "active dropped");
      chk(in_mode, 1'b1, "mode flag");
      chk(ev.flags, 32'h0000_0002, "entry flags");
      chk(ev.dr7, 32'h0000_0400, "entry debug");
      chk(ev.instr_pointer, 32'h0000_8000, "entry pointer");
      chk(ev.cs_base, base, "entry base");
      chk(ev.cr0, cs.cr0 & ~32'h8000_000D, "entry cr0");
      chk(mode_ctl, 5'h1F, "mode controls");
      chk(a20_eff, 1'b0, "a20 not masked");
      brd(9'h1FC);
      chk(d, cs.cr0, "saved cr0");
      brd(9'h1F0);
      chk(d, cs.instr_pointer, "saved pointer");
      brd(9'h1A4);
      chk(d, iov ? trap_dw : 32'h0, "trap dword");
      brd(9'h100);
      chk(d[16], halted, "halt slot");
      brd(9'h0F8);
      chk(d, base, "saved base");
      for (int k = 0; k < 2; k++)
      begin
        @(posedge sys_clk);
        xeip <= $urandom;
        sel  <= 16'($urandom);
        op32 <= k[0];
        xv   <= 1'b1;
        @(posedge sys_clk);
        xv <= 1'b0;
        #1 chk(xeip_q, op32 ? xeip : {16'h0, xeip[15:0]}, "pointer width");
        chk(fbase_q, {12'h0, sel, 4'h0}, "far base");
      end
      // a request during the handler must wait for exit
      if (r == 1)
      begin
        @(posedge sys_clk);
        req <= 1'b1;
        @(posedge sys_clk);
        req <= 1'b0;
      end
      ne = $urandom;
      nh = 1'($urandom);
      bwr(9'h1F0, ne);
      bwr(9'h100, {15'h0, nh, 16'h0});
      // move the base by one aligned 32-Kbyte step each stay
      bwr(9'h0F8, base + 32'h0000_8000);
      do_resume();
      wait_for(restore_load, 1'b1);
      chk(rv.instr_pointer, ne, "edited pointer");
      chk(rv.cr3, cs.cr3, "restored cr3");
      chk(to_halt, nh, "halt return");
      base = base + 32'h0000_8000;
      wait_for(active_n, 1'b1);
    end
    wait_for(active_n, 1'b0);
    wait_for(entry_load, 1'b1);
    chk(ev.cs_base, base, "relocated base");
    bwr(9'h0F8, 32'h0003_4000);
    do_resume();
    wait_for(shutdown, 1'b1);
    complete_run();
  end
endmodule

// file: pkg/smm_defines.svh
// constants of the management-mode entry/exit unit
// assumes: included by bare name from the sequencer rtl file
// Operation
// - active output low throughout management mode
// - acknowledge, save state, then jump handler
// - resume restores state, negates active, continues
// - 512-byte save area fills down from top
// - default base 0003_0000h, 64-Kbyte region
// - entry flags, debug, pointer, segments fixed
// - entry clears cr0 bits 0,2,3,31 only
// - mask interrupts, single step, debug, A20
// - real addressing, 4-Gbyte limits, 16-bit defaults
// - default-size transfers truncate pointer to 16
// - far targets limited to 20-bit bases
// - vectors from real-mode table
// - each item at its fixed offset
// - handler edits restored on resume
// - I/O trap entries valid only on I/O
// - relocatable 32K-aligned base, misaligned means shutdown
// - halt slot bit16 records and selects halt
// - interrupt input edge latched while busy
`ifndef SMM_DEFINES_SVH
`define SMM_DEFINES_SVH

// memory map
`define SMM_BASE_RST     32'h0003_0000
`define SMM_AREA_LO      16'hFE00
`define SMM_AREA_TOP     16'hFFFF
`define SMM_OFF_CR0      16'hFFFC
`define SMM_OFF_STRIDE   16'h0004
`define SMM_OFF_IOTRAP   16'hFFA4
`define SMM_OFF_IOEIP    16'hFF9C
`define SMM_OFF_HALT     16'hFF00
`define SMM_OFF_REVID    16'hFEFC
`define SMM_OFF_SMBASE   16'hFEF8
`define SMM_ALIGN_BITS   15
// save sequence
`define SMM_ITEMS        5'h13
`define SMM_LAST_ITEM    5'h12
`define SMM_K_DR7        5'h0D
`define SMM_K_IOTRAP     5'h0E
`define SMM_K_IOEIP      5'h0F
`define SMM_K_HALT       5'h10
`define SMM_K_REVID      5'h11
`define SMM_K_SMBASE     5'h12
`define SMM_HALT_BIT     16
// entry values
`define SMM_FLAGS_ENTRY  32'h0000_0002
`define SMM_DR7_ENTRY    32'h0000_0400
`define SMM_EIP_ENTRY    32'h0000_8000
`define SMM_CR0_CLR      32'h8000_000D
`define SMM_REVID_VAL    32'h0003_0002

`endif

// file: pkg/smm_pkg.sv
// types of the management-mode entry/exit unit
// assumes: compiled before any rtl file
package smm_pkg;

  // gray codes along idle-ack-save-active-restore-exit
  typedef enum logic [2:0] {
    SMM_IDLE    = 3'h0,
    SMM_ACK     = 3'h1,
    SMM_SAVE    = 3'h3,
    SMM_ACTIVE  = 3'h2,
    SMM_RESTORE = 3'h6,
    SMM_EXIT    = 3'h7,
    SMM_SHUT    = 3'h5
  } smm_state_e;

  // architectural state that is saved and restored
  typedef struct packed {
    logic [31:0]      cr0;
    logic [31:0]      cr3;
    logic [31:0]      flags_reg;
    logic [31:0]      instr_pointer;
    logic [7:0][31:0] gpr;    // index 0 eax .. 7 edi
    logic [31:0]      dr6;
    logic [31:0]      dr7;
  } smm_core_s;

  // values loaded into the core on entry
  typedef struct packed {
    logic [31:0] flags;
    logic [31:0] dr7;
    logic [31:0] instr_pointer;
    logic [31:0] cr0;
    logic [31:0] cs_base;
  } smm_entry_s;

  // operating-mode controls while in management mode
  typedef struct packed {
    logic real_mode;
    logic limit_4g;
    logic def_16bit;
    logic nmi_init_block;
    logic real_ivt;
  } smm_mode_s;

endpackage

// file: rtl/smm_entry_exit.sv
// management-mode entry and exit sequencer
// assumes: core offers instruction boundaries and a state snapshot;
// handler reaches the save area over the plain register port
`timescale 1ns/100ps
`include "smm_defines.svh"
module smm_entry_exit (
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  input  wire logic              sys_mgmt_irq_n,
  input  wire logic              addr_bit20_mask_n,
  input  wire logic              instr_boundary,
  input  wire logic              core_halted,
  input  wire smm_pkg::smm_core_s core_state,
  input  wire logic              io_cycle_valid,
  input  wire logic [31:0]       io_trap_dword,
  input  wire logic [31:0]       io_trap_eip,
  input  wire logic              resume_from_mgmt_instr,
  input  wire logic              xfer_valid,
  input  wire logic              xfer_op32,
  input  wire logic [31:0]       xfer_eip,
  input  wire logic [15:0]       far_selector,
  input  wire logic [8:0]        bus_addr,
  input  wire logic [31:0]       bus_wdata,
  input  wire logic              bus_wr,
  input  wire logic              bus_rd,
  output logic [31:0]            bus_rdata,
  output logic                   sys_mgmt_active_n,
  output logic                   sys_mgmt_mode,
  output logic                   entry_load,
  output smm_pkg::smm_entry_s    entry_vals,
  output logic                   restore_load,
  output smm_pkg::smm_core_s     restore_vals,
  output logic                   return_to_halt,
  output logic                   shutdown,
  output smm_pkg::smm_mode_s     mode_ctl,
  output logic                   a20_mask_eff,
  output logic [31:0]            xfer_eip_q,
  output logic [31:0]            far_base_q
);

  ////////////////////////////////////////////////////////////
  // decode helpers

  // byte offset of save item k, walking down the map
  function automatic logic [15:0] item_off(input logic [4:0] k);
    logic [15:0] off;
    off = `SMM_OFF_CR0;
    unique case (k)
      `SMM_K_IOTRAP: off = `SMM_OFF_IOTRAP;
      `SMM_K_IOEIP:  off = `SMM_OFF_IOEIP;
      `SMM_K_HALT:   off = `SMM_OFF_HALT;
      `SMM_K_REVID:  off = `SMM_OFF_REVID;
      `SMM_K_SMBASE: off = `SMM_OFF_SMBASE;
      default:       off = 16'(`SMM_OFF_CR0 - `SMM_OFF_STRIDE * 16'(k));
    endcase
    return off;
  endfunction

  // word index of an offset inside the 512-byte area
  function automatic logic [6:0] word_idx(input logic [15:0] off);
    return off[8:2];
  endfunction

  ////////////////////////////////////////////////////////////
  // state

  smm_pkg::smm_state_e state_q;   // sequencer state
  smm_pkg::smm_core_s  snap_q;    // state snapshot at accept
  logic        irq_prev_q;        // last sampled request level
  logic        pend_q;            // latched request edge
  logic        active_q;          // acknowledge level
  logic        halt_q;            // entry came from halt
  logic        io_ok_q;           // request met a valid I/O cycle
  logic [31:0] smbase_q;          // current management base
  logic [31:0] smbase_rst_q;      // base read back on resume
  logic [4:0]  k_q;               // save/restore item counter
  logic        cap_v_q;           // read data due this cycle
  logic [4:0]  cap_k_q;           // item of that read data
  logic        bus_rd_ok_q;       // bus read was legal
  logic        irq_fall;          // request edge seen
  logic        accept;            // request taken this cycle
  logic        mem_we;
  logic        mem_re;
  logic [6:0]  mem_idx;
  logic [31:0] mem_wdata;
  logic [31:0] mem_rdata;
  logic [31:0] save_val;
  logic        rst_done;          // last restore word captured

  assign irq_fall = irq_prev_q & ~sys_mgmt_irq_n;
  assign accept   = (state_q == smm_pkg::SMM_IDLE) & pend_q & instr_boundary;
  assign rst_done = cap_v_q & (cap_k_q == `SMM_LAST_ITEM);

  ////////////////////////////////////////////////////////////
  // request edge latch; a new edge beats the clear
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      irq_prev_q <= 1'b1;
      pend_q     <= 1'b0;
    end
    else
    begin
      irq_prev_q <= sys_mgmt_irq_n;
      if (irq_fall)
      begin
        pend_q <= 1'b1;
      end
      else if (accept)
      begin
        pend_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////
  // sequencer
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      state_q <= smm_pkg::SMM_IDLE;
      k_q     <= 5'h0;
    end
    else
    begin
      unique case (state_q)
        smm_pkg::SMM_IDLE:
        begin
          // only at an instruction boundary
          if (accept)
          begin
            state_q <= smm_pkg::SMM_ACK;
          end
        end
        smm_pkg::SMM_ACK:
        begin
          // one cycle of acknowledge before any write
          state_q <= smm_pkg::SMM_SAVE;
          k_q     <= 5'h0;
        end
        smm_pkg::SMM_SAVE:
        begin
          k_q <= k_q + 5'h1;
          if (k_q == `SMM_LAST_ITEM)
          begin
            state_q <= smm_pkg::SMM_ACTIVE;
          end
        end
        smm_pkg::SMM_ACTIVE:
        begin
          if (resume_from_mgmt_instr)
          begin
            state_q <= smm_pkg::SMM_RESTORE;
            k_q     <= 5'h0;
          end
        end
        smm_pkg::SMM_RESTORE:
        begin
          if (k_q != `SMM_ITEMS)
          begin
            k_q <= k_q + 5'h1;
          end
          if (rst_done)
          begin
            // misaligned base cannot be entered again
            if (smbase_rst_q[`SMM_ALIGN_BITS-1:0] != '0 && cap_k_q != `SMM_K_SMBASE)
            begin
              state_q <= smm_pkg::SMM_SHUT;
            end
            else if (mem_rdata[`SMM_ALIGN_BITS-1:0] != '0)
            begin
              state_q <= smm_pkg::SMM_SHUT;
            end
            else
            begin
              state_q <= smm_pkg::SMM_EXIT;
            end
          end
        end
        smm_pkg::SMM_EXIT:
        begin
          state_q <= smm_pkg::SMM_IDLE;
        end
        smm_pkg::SMM_SHUT:
        begin
          // left only by reset
          state_q <= smm_pkg::SMM_SHUT;
        end
        default:
        begin
          state_q <= smm_pkg::SMM_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////
  // acknowledge output, held across the whole stay
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      active_q <= 1'b0;
    end
    else if (accept)
    begin
      active_q <= 1'b1;
    end
    else if (state_q == smm_pkg::SMM_EXIT)
    begin
      active_q <= 1'b0;
    end
  end

  assign sys_mgmt_active_n = ~active_q;
  assign sys_mgmt_mode     = active_q;

  ////////////////////////////////////////////////////////////
  // snapshot of core and entry conditions
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      snap_q  <= '0;
      halt_q  <= 1'b0;
      io_ok_q <= 1'b0;
    end
    else if (accept)
    begin
      snap_q  <= core_state;
      halt_q  <= core_halted;
      io_ok_q <= io_cycle_valid;
    end
  end

  ////////////////////////////////////////////////////////////
  // value of save item k; unlisted slots are never written by the save
  always_comb
  begin
    save_val = '0;
    unique case (k_q)
      5'h00: save_val = snap_q.cr0;
      5'h01: save_val = snap_q.cr3;
      5'h02: save_val = snap_q.flags_reg;
      5'h03: save_val = snap_q.instr_pointer;
      5'h0C: save_val = snap_q.dr6;
      `SMM_K_DR7: save_val = snap_q.dr7;
      // stale trap data would mislead the handler
      `SMM_K_IOTRAP: save_val = io_ok_q ? io_trap_dword : '0;
      `SMM_K_IOEIP:  save_val = io_ok_q ? io_trap_eip : '0;
      `SMM_K_HALT:   save_val = {15'h0000, halt_q, 16'h0000};
      `SMM_K_REVID:  save_val = `SMM_REVID_VAL;
      `SMM_K_SMBASE: save_val = smbase_q;
      default:       save_val = snap_q.gpr[3'(5'h0B - k_q)];
    endcase
  end

  ////////////////////////////////////////////////////////////
  // memory port: sequencer in save/restore, handler in active
  always_comb
  begin
    mem_we    = 1'b0;
    mem_re    = 1'b0;
    mem_idx   = bus_addr[8:2];
    mem_wdata = bus_wdata;
    if (state_q == smm_pkg::SMM_SAVE)
    begin
      mem_we    = 1'b1;
      mem_idx   = word_idx(item_off(k_q));
      mem_wdata = save_val;
    end
    else if (state_q == smm_pkg::SMM_RESTORE)
    begin
      mem_re  = (k_q != `SMM_ITEMS);
      mem_idx = word_idx(item_off(k_q));
    end
    else if (state_q == smm_pkg::SMM_ACTIVE)
    begin
      mem_we = bus_wr;
      mem_re = bus_rd;
    end
  end

  smm_save_mem #(
    .AW (7),
    .DW (32)
  ) u_mem (
    .sys_clk (sys_clk),
    .we      (mem_we),
    .re      (mem_re),
    .idx     (mem_idx),
    .wdata   (mem_wdata),
    .rdata_q (mem_rdata)
  );

  // bus reads outside management mode answer zero
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      bus_rd_ok_q <= 1'b0;
    end
    else
    begin
      bus_rd_ok_q <= bus_rd & (state_q == smm_pkg::SMM_ACTIVE);
    end
  end

  assign bus_rdata = bus_rd_ok_q ? mem_rdata : '0;

  ////////////////////////////////////////////////////////////
  // restore capture, one word per cycle
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      cap_v_q <= 1'b0;
      cap_k_q <= 5'h0;
    end
    else
    begin
      cap_v_q <= mem_re & (state_q == smm_pkg::SMM_RESTORE);
      cap_k_q <= k_q;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      restore_vals   <= '0;
      return_to_halt <= 1'b0;
    end
    else if (cap_v_q)
    begin
      // handler edits come back through memory
      unique case (cap_k_q)
        5'h00: restore_vals.cr0    <= mem_rdata;
        5'h01: restore_vals.cr3    <= mem_rdata;
        5'h02: restore_vals.flags_reg <= mem_rdata;
        5'h03: restore_vals.instr_pointer    <= mem_rdata;
        5'h0C: restore_vals.dr6    <= mem_rdata;
        `SMM_K_DR7: restore_vals.dr7 <= mem_rdata;
        `SMM_K_HALT: return_to_halt <= mem_rdata[`SMM_HALT_BIT];
        `SMM_K_IOTRAP, `SMM_K_IOEIP, `SMM_K_REVID, `SMM_K_SMBASE:
        begin
          // read-only or handled below
        end
        default: restore_vals.gpr[3'(5'h0B - cap_k_q)] <= mem_rdata;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////
  // management base, kept until reset or handler relocation
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      smbase_q     <= `SMM_BASE_RST;
      smbase_rst_q <= `SMM_BASE_RST;
    end
    else if (cap_v_q && cap_k_q == `SMM_K_SMBASE)
    begin
      smbase_rst_q <= mem_rdata;
      // only an aligned base takes effect
      if (mem_rdata[`SMM_ALIGN_BITS-1:0] == '0)
      begin
        smbase_q <= mem_rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////
  // entry load and resume load pulses
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      entry_load   <= 1'b0;
      entry_vals   <= '0;
      restore_load <= 1'b0;
      shutdown     <= 1'b0;
    end
    else
    begin
      entry_load   <= (state_q == smm_pkg::SMM_SAVE) && (k_q == `SMM_LAST_ITEM);
      restore_load <= rst_done && (state_q == smm_pkg::SMM_RESTORE);
      shutdown     <= (state_q == smm_pkg::SMM_SHUT);
      // interrupt and trap flags clear, debug traps off
      entry_vals.flags   <= `SMM_FLAGS_ENTRY;
      entry_vals.dr7     <= `SMM_DR7_ENTRY;
      entry_vals.instr_pointer     <= `SMM_EIP_ENTRY;
      entry_vals.cr0     <= snap_q.cr0 & ~`SMM_CR0_CLR;
      entry_vals.cs_base <= smbase_q;
    end
  end

  ////////////////////////////////////////////////////////////
  // mode controls and address helpers
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      mode_ctl     <= '0;
      a20_mask_eff <= 1'b0;
      xfer_eip_q   <= '0;
      far_base_q   <= '0;
    end
    else
    begin
      mode_ctl.real_mode      <= active_q;
      mode_ctl.limit_4g       <= active_q;
      mode_ctl.def_16bit      <= active_q;
      mode_ctl.nmi_init_block <= active_q;
      mode_ctl.real_ivt       <= active_q;
      // address mask pin ignored while in management mode
      a20_mask_eff <= ~active_q & ~addr_bit20_mask_n;
      if (xfer_valid)
      begin
        xfer_eip_q <= (active_q && !xfer_op32) ? {16'h0000, xfer_eip[15:0]}
                                               : xfer_eip;
        far_base_q <= {12'h000, far_selector, 4'h0};
      end
    end
  end

  ////////////////////////////////////////////////////////////
  // checks

  sequence ack_seq;
    state_q == smm_pkg::SMM_ACK;
  endsequence

  sequence first_save_seq;
    mem_we && mem_idx == word_idx(`SMM_OFF_CR0) && !sys_mgmt_active_n;
  endsequence

  save_start_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ack_seq |=> first_save_seq)
    else $error("save does not start at area top");

  ack_first_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state_q == smm_pkg::SMM_SAVE) |-> $past(active_q))
    else $error("save write before acknowledge");

  active_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state_q == smm_pkg::SMM_ACTIVE) |-> !sys_mgmt_active_n)
    else $error("active output dropped in mode");

  entry_vals_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    entry_load |-> entry_vals.instr_pointer == `SMM_EIP_ENTRY && entry_vals.flags == `SMM_FLAGS_ENTRY)
    else $error("wrong entry pointer or flags");

  cr0_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    entry_load |-> (entry_vals.cr0 | `SMM_CR0_CLR) == (snap_q.cr0 | `SMM_CR0_CLR)
                   && (entry_vals.cr0 & `SMM_CR0_CLR) == '0)
    else $error("cr0 entry value wrong");

  edge_latch_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $fell(sys_mgmt_irq_n) |=> pend_q || state_q == smm_pkg::SMM_ACK)
    else $error("request edge lost");

  exit_negate_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    resume_from_mgmt_instr && state_q == smm_pkg::SMM_ACTIVE
      |-> ##[21:22] sys_mgmt_active_n || shutdown)
    else $error("active not negated after resume");

  eip_trunc_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    xfer_valid && active_q && !xfer_op32 |=> xfer_eip_q[31:16] == 16'h0000)
    else $error("pointer not truncated");

  io_trap_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_q == smm_pkg::SMM_SAVE && k_q == `SMM_K_IOTRAP && !io_ok_q |-> mem_wdata == '0)
    else $error("trap dword written without I/O cycle");

endmodule

// file: rtl/smm_save_mem.sv
// save-area memory, one port, registered read data
// assumes: caller never reads and writes in one cycle
`timescale 1ns/100ps
module smm_save_mem #(
  parameter int AW = 7,
  parameter int DW = 32
) (
  input  wire logic          sys_clk,
  input  wire logic          we,
  input  wire logic          re,
  input  wire logic [AW-1:0] idx,
  input  wire logic [DW-1:0] wdata,
  output logic      [DW-1:0] rdata_q
);

  logic [DW-1:0] mem [2**AW];  // words of the area

  ////////////////////////////////////////////////////////////
  // write port
  always_ff @(posedge sys_clk)
  begin
    if (we)
    begin
      mem[idx] <= wdata;
    end
  end

  // read port, data one cycle later
  always_ff @(posedge sys_clk)
  begin
    if (re)
    begin
      rdata_q <= mem[idx];
    end
  end

endmodule
